// File: float_mode_pulse_sign_control.sv
// Purpose: float-mode configuration registers and signed burst accumulation
// Assumes: register port and sample strobes come from same-clock logic
// Notes:   burst start and a sample in one cycle: clear, then add sample
`timescale 1ns/1ps
`default_nettype none
module float_mode_pulse_sign_control #(
  parameter int SAMPLE_W = 14,
  parameter int ACC_W    = 20
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output var  logic [15:0]             reg_rdata,
  input  wire logic                    slot_b_start,
  input  wire logic                    burst_start_a,
  input  wire logic                    burst_start_b,
  input  wire logic                    sample_valid,
  input  wire logic                    sample_slot_b,
  input  wire logic [SAMPLE_W-1:0]     sample_data,
  output var  logic                    integrator_buffer_enable,
  output var  logic [1:0]              emitter_drive,
  output var  logic signed [ACC_W-1:0] accum_a,
  output var  logic signed [ACC_W-1:0] accum_b
);

  typedef struct packed {
    float_sign_pkg::cfg_t    cfg;
    float_sign_pkg::timing_t tim;
    logic [15:0]             rdata;
    logic [1:0]              idx_a;
    logic [1:0]              idx_b;
    logic [ACC_W-1:0]        acc_a;
    logic [ACC_W-1:0]        acc_b;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // sign of a pulse: bit 1 of a pair field is the first, bit 0 the second
  function automatic logic subtract_pulse(input logic [1:0] one,
                                          input logic [1:0] two,
                                          input logic [1:0] idx);
    unique case (idx)
      2'h0: subtract_pulse = one[1];
      2'h1: subtract_pulse = one[0];
      2'h2: subtract_pulse = two[1];
      2'h3: subtract_pulse = two[0];
    endcase
  endfunction : subtract_pulse

  function automatic logic [ACC_W-1:0] signed_term(
      input logic [SAMPLE_W-1:0] smp, input logic neg);
    logic [ACC_W-1:0] ext;
    ext = ACC_W'(smp);
    signed_term = neg ? ACC_W'(-ext) : ext;
  endfunction : signed_term

  always_comb begin
    s_next = s_reg;
    if (reg_wr) begin
      if (reg_addr == float_sign_pkg::CFG_ADDR) begin
        s_next.cfg = reg_wdata & float_sign_pkg::CFG_WMASK;
      end else if (reg_addr == float_sign_pkg::TIMING_ADDR) begin
        s_next.tim = reg_wdata & float_sign_pkg::TIMING_WMASK;
      end
    end
    if (reg_rd) begin
      if (reg_addr == float_sign_pkg::CFG_ADDR) begin
        s_next.rdata = s_reg.cfg;
      end else if (reg_addr == float_sign_pkg::TIMING_ADDR) begin
        s_next.rdata = s_reg.tim;
      end else begin
        s_next.rdata = 16'h0000;
      end
    end
    if (burst_start_a) begin
      s_next.idx_a = 2'h0;
      s_next.acc_a = '0;
    end
    if (burst_start_b) begin
      s_next.idx_b = 2'h0;
      s_next.acc_b = '0;
    end
    if (sample_valid && !sample_slot_b) begin
      s_next.acc_a = s_next.acc_a + signed_term(sample_data,
        subtract_pulse(s_reg.cfg.slot_a_pair_one_sign,
                       s_reg.cfg.slot_a_pair_two_sign,
                       s_next.idx_a));
      s_next.idx_a = s_next.idx_a + 2'h1;
    end
    if (sample_valid && sample_slot_b) begin
      s_next.acc_b = s_next.acc_b + signed_term(sample_data,
        subtract_pulse(s_reg.cfg.slot_b_pair_one_sign,
                       s_reg.cfg.slot_b_pair_two_sign,
                       s_next.idx_b));
      s_next.idx_b = s_next.idx_b + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg.cfg   <= float_sign_pkg::CFG_RESET;
      s_reg.tim   <= float_sign_pkg::TIMING_RESET;
      s_reg.rdata <= 16'h0000;
      s_reg.idx_a <= 2'h0;
      s_reg.idx_b <= 2'h0;
      s_reg.acc_a <= '0;
      s_reg.acc_b <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  float_pulse_timer u_timer (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .start  (slot_b_start),
    .delay  (s_reg.tim.slot_b_float_first_pulse_delay),
    .width  (s_reg.tim.slot_b_float_pulse_width),
    .select (s_reg.tim.slot_b_float_emitter_select),
    .drive  (emitter_drive)
  );

  assign reg_rdata                = s_reg.rdata;
  assign integrator_buffer_enable = s_reg.cfg.integrator_buffer_enable;
  assign accum_a                  = s_reg.acc_a;
  assign accum_b                  = s_reg.acc_b;

endmodule : float_mode_pulse_sign_control
`default_nettype wire

// File: float_mode_pulse_sign_control_properties.sv
// Purpose: port checks for the float mode config block
// Assumes: one clock, sync active-high reset
// Notes:   bound to every instance
`timescale 1ns/1ps
`default_nettype none
module float_mode_pulse_sign_control_props #(
  parameter int ACC_W = 20
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    ce,
  input wire logic [7:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  input wire logic                    burst_start_b,
  input wire logic                    sample_valid,
  input wire logic                    sample_slot_b,
  input wire logic                    integrator_buffer_enable,
  input wire logic [1:0]              emitter_drive,
  input wire logic signed [ACC_W-1:0] accum_a,
  input wire logic signed [ACC_W-1:0] accum_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic cfg_wr = ce && reg_wr && reg_addr == float_sign_pkg::CFG_ADDR;
  wire logic bad_rd = ce && reg_rd && reg_addr != float_sign_pkg::CFG_ADDR
    && reg_addr != float_sign_pkg::TIMING_ADDR;
  property p_reset_vals;
    $fell(reset) |-> !integrator_buffer_enable && emitter_drive == 2'h0
      && reg_rdata == 16'h0000 && accum_b == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value");
  property p_buf_wr;
    cfg_wr |=> integrator_buffer_enable == $past(reg_wdata[7]);
  endproperty
  a_buf_wr: assert property (p_buf_wr) else $error("buffer bit");
  property p_buf_hold;
    !cfg_wr |=> $stable(integrator_buffer_enable);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer moved");
  property p_bad_rd;
    bad_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read");
  property p_clear;
    ce && burst_start_b && !sample_valid |=> accum_b == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_freeze;
    !ce |=> $stable(accum_a) && $stable(accum_b) && $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved at ce low");
  property p_one_hot;
    emitter_drive != 2'h3;
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("two emitters");
  property p_slot_a_only;
    ce && sample_valid && !sample_slot_b && !burst_start_b |=> $stable(accum_b);
  endproperty
  a_slot_a_only: assert property (p_slot_a_only) else $error("b moved");
endmodule : float_mode_pulse_sign_control_props
bind float_mode_pulse_sign_control float_mode_pulse_sign_control_props
  #(.ACC_W(ACC_W)) u_props (.clk(clk), .reset(reset), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .burst_start_b(burst_start_b),
  .sample_valid(sample_valid), .sample_slot_b(sample_slot_b),
  .integrator_buffer_enable(integrator_buffer_enable),
  .emitter_drive(emitter_drive), .accum_a(accum_a), .accum_b(accum_b));
`default_nettype wire

// File: float_mode_pulse_sign_control_test.sv
// Purpose: self-checking bench for the float mode config block
// Assumes: default parameters, 50 ns clock
// Notes:   sample and timer figures follow the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module float_mode_pulse_sign_control_test;
  logic clk = 0, reset = 1, ce = 1, reg_wr = 0, reg_rd = 0;
  logic slot_b_start = 0, burst_start_a = 0, burst_start_b = 0;
  logic sample_valid = 0, sample_slot_b = 0;
  logic [7:0]         reg_addr = '0;
  logic [15:0]        reg_wdata = '0;
  logic [13:0]        sample_data = '0;
  logic [15:0]        reg_rdata;
  logic               integrator_buffer_enable;
  logic [1:0]         emitter_drive;
  logic signed [19:0] accum_a, accum_b;
  int                 bad_count = 0, checked = 0;
  float_mode_pulse_sign_control u_float_mode_pulse_sign_control (
    .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slot_b_start(slot_b_start),
    .burst_start_a(burst_start_a), .burst_start_b(burst_start_b),
    .sample_valid(sample_valid), .sample_slot_b(sample_slot_b),
    .sample_data(sample_data),
    .integrator_buffer_enable(integrator_buffer_enable),
    .emitter_drive(emitter_drive), .accum_a(accum_a), .accum_b(accum_b));
  initial forever #25 clk = ~clk;
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(string n, logic [19:0] got, logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 20'(reg_rdata), 20'(exp));
  endtask : rd
  // sum of samples 100..800 with the per-pulse sign pattern
  function automatic logic [19:0] exp_acc(logic [1:0] one, logic [1:0] two);
    logic [3:0]  s;
    logic [19:0] t;
    s = {one, two};
    t = '0;
    for (int k = 0; k < 8; k++)
      t = s[3 - k % 4] ? t - 20'(100 * (k + 1)) : t + 20'(100 * (k + 1));
    return t;
  endfunction : exp_acc
  task automatic test_regs();
    rd(float_sign_pkg::CFG_ADDR, 16'h0000);
    rd(float_sign_pkg::TIMING_ADDR, 16'h0320);
    wr(float_sign_pkg::CFG_ADDR, 16'hffe7);
    chk("buffer", 20'(integrator_buffer_enable), 20'h1);
    rd(float_sign_pkg::CFG_ADDR, 16'h0fe6);
    rd(8'h00, 16'h0000);
    wr(float_sign_pkg::CFG_ADDR, 16'h0000);
    chk("buffer", 20'(integrator_buffer_enable), 20'h0);
  endtask : test_regs
  task automatic test_signs();
    logic [1:0] c, n;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      n = ~c;
      wr(float_sign_pkg::CFG_ADDR, {4'h0, c, n, 1'b0, n, 2'h0, c, 1'b0});
      @(posedge clk);
      burst_start_a <= 1'b1;
      burst_start_b <= 1'b1;
      @(posedge clk);
      burst_start_a <= 1'b0;
      burst_start_b <= 1'b0;
      for (int s = 0; s < 16; s++) begin
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_slot_b <= s[3];
        sample_data <= 14'(100 * (s % 8 + 1));
      end
      @(posedge clk);
      sample_valid <= 1'b0;
      #1 chk("accum_a", accum_a, exp_acc(c, n));
      chk("accum_b", accum_b, exp_acc(n, c));
    end
  endtask : test_signs
  task automatic test_freeze();
    @(posedge clk);
    ce <= 1'b0;
    sample_valid <= 1'b1;
    sample_slot_b <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    sample_valid <= 1'b0;
    #1 chk("frozen", accum_b, exp_acc(2'h0, 2'h3));
  endtask : test_freeze
  // one float pulse: select, width and delay in steps
  task automatic pulse_case(int sel, int w, int dly);
    logic [1:0] want;
    want = (2'(sel) == float_sign_pkg::SEL_FIRST)  ? 2'h1 :
           (2'(sel) == float_sign_pkg::SEL_SECOND) ? 2'h2 : 2'h0;
    wr(float_sign_pkg::TIMING_ADDR, {2'(sel), 1'b0, 5'(w), 8'(dly)});
    @(posedge clk);
    slot_b_start <= 1'b1;
    @(posedge clk);
    slot_b_start <= 1'b0;
    if (dly > 0) begin
      repeat (float_sign_pkg::STEP_CYCLES * dly - 1) @(posedge clk);
      #1 chk("drive", 20'(emitter_drive), 20'h0);
      @(posedge clk);
    end
    #1 chk("drive", 20'(emitter_drive), 20'(want));
    repeat (float_sign_pkg::STEP_CYCLES * w - 1) @(posedge clk);
    #1 chk("drive", 20'(emitter_drive), 20'(want));
    @(posedge clk);
    #1 chk("drive", 20'(emitter_drive), 20'h0);
  endtask : pulse_case
  task automatic test_timer();
    for (int sel = 0; sel < 4; sel++) begin
      pulse_case(sel, 1, 1);
    end
    pulse_case(1, 2, 0);
  endtask : test_timer
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_signs();
    test_freeze();
    test_timer();
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : float_mode_pulse_sign_control_test
`default_nettype wire

// File: float_pulse_timer.sv
// Purpose: slot B float-mode emitter pulse timer
// Assumes: start is a one-cycle pulse from logic on the same clock
// Notes:   settings are captured at start; a new start restarts the timer
`timescale 1ns/1ps
`default_nettype none
module float_pulse_timer (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] delay,
  input  wire logic [4:0] width,
  input  wire logic [1:0] select,
  output var  logic [1:0] drive
);

  localparam logic [4:0] TICK_LAST = 5'(float_sign_pkg::STEP_CYCLES - 1);

  typedef struct packed {
    float_sign_pkg::tstate_t st;
    logic [4:0]              tick;
    logic [7:0]              left;
    logic [4:0]              width;
    logic [1:0]              drive;
    logic [1:0]              sel_onehot;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [1:0] onehot(input logic [1:0] sel);
    unique case (sel)
      float_sign_pkg::SEL_FIRST:  onehot = 2'h1;
      float_sign_pkg::SEL_SECOND: onehot = 2'h2;
      default:                    onehot = 2'h0;
    endcase
  endfunction : onehot

  always_comb begin
    s_next = s_reg;
    if (start) begin
      s_next.sel_onehot = onehot(select);
      s_next.width      = width;
      s_next.tick       = 5'h00;
      s_next.drive      = 2'h0;
      if (onehot(select) == 2'h0 || width == 5'h00) begin
        s_next.st = float_sign_pkg::T_IDLE;
      end else if (delay == 8'h00) begin
        s_next.st    = float_sign_pkg::T_PULSE;
        s_next.left  = {3'h0, width};
        s_next.drive = onehot(select);
      end else begin
        s_next.st   = float_sign_pkg::T_DELAY;
        s_next.left = delay;
      end
    end else begin
      unique case (s_reg.st)
        float_sign_pkg::T_IDLE: begin
          s_next.drive = 2'h0;
        end
        float_sign_pkg::T_DELAY: begin
          s_next.tick = s_reg.tick + 5'h01;
          if (s_reg.tick == TICK_LAST) begin
            s_next.tick = 5'h00;
            s_next.left = s_reg.left - 8'h01;
            if (s_reg.left == 8'h01) begin
              s_next.st    = float_sign_pkg::T_PULSE;
              s_next.left  = {3'h0, s_reg.width};
              s_next.drive = s_reg.sel_onehot;
            end
          end
        end
        float_sign_pkg::T_PULSE: begin
          s_next.tick = s_reg.tick + 5'h01;
          if (s_reg.tick == TICK_LAST) begin
            s_next.tick = 5'h00;
            s_next.left = s_reg.left - 8'h01;
            if (s_reg.left == 8'h01) begin
              s_next.st    = float_sign_pkg::T_IDLE;
              s_next.drive = 2'h0;
            end
          end
        end
        default: begin
          s_next.st    = float_sign_pkg::T_IDLE;
          s_next.drive = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{st: float_sign_pkg::T_IDLE, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign drive = s_reg.drive;

endmodule : float_pulse_timer
`default_nettype wire

// File: float_sign_pkg.sv
// What this block does
// - slot B float pulse width is five bits in 1 us steps, reset 3.
// - slot B delay to first float pulse is eight bits, reset 32.
// - slot B pair-two sign: 00 add, 01 +/-, 10 -/+, 11 subtract both.
// - slot A pair-two sign uses the same encodings, reset add both.
// - slot B pair-one sign: 00 add, 01 +/-, 10 -/+, 11 subtract both.
// - slot A pair-one sign uses the same encodings, reset add both.
// - sign pattern repeats every four pulses of a burst.
// - integrator buffer enable bit, reset zero, drives integrator reconfig.
// - slot B emitter select: 0 none, 1 first, 2 second emitter.
//
// Purpose: shared register map, field layouts and timing constants
// Assumes: 20 MHz clock, 16-bit register port
// Notes:   reserved bits are not stored and read as zero
package float_sign_pkg;

  localparam logic [7:0]  CFG_ADDR      = 8'h58;
  localparam logic [7:0]  TIMING_ADDR   = 8'h59;

  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [15:0] TIMING_RESET  = 16'h0320;
  localparam logic [15:0] CFG_WMASK     = 16'h0fe6;
  localparam logic [15:0] TIMING_WMASK  = 16'hdfff;

  localparam int          CLK_PERIOD_NS = 50;
  localparam int          STEP_NS       = 1000;
  localparam int          STEP_CYCLES   =
    (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam logic [1:0]  SEL_FIRST     = 2'h1;
  localparam logic [1:0]  SEL_SECOND    = 2'h2;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] slot_b_pair_two_sign;
    logic [1:0] slot_a_pair_two_sign;
    logic       integrator_buffer_enable;
    logic [1:0] slot_b_pair_one_sign;
    logic [1:0] rsvd_mid;
    logic [1:0] slot_a_pair_one_sign;
    logic       rsvd_lo;
  } cfg_t;

  typedef struct packed {
    logic [1:0] slot_b_float_emitter_select;
    logic       rsvd;
    logic [4:0] slot_b_float_pulse_width;
    logic [7:0] slot_b_float_first_pulse_delay;
  } timing_t;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b001,
    T_DELAY = 3'b010,
    T_PULSE = 3'b100
  } tstate_t;

endpackage : float_sign_pkg
